// >>> core/ppm_pin_mux.sv
// Pin-function multiplexer for ports 3 to 6: port bits versus bus and peripheral signals.
// Assumes port data/direction registers and peripheral enables live outside; one clock.
// Functional notes
// - Upper write strobe drives pin only with bus on, 16-bit width, strobe enabled.
// - Hold request input taken from pin only with bus and hold enabled.
// - Hold acknowledge driven only with bus and hold enabled.
// - Ready input sampled from pin only with bus and ready enabled.
// - Clock output on pin only with bus and clock output enabled.
// - Channel A transmit data owns its pin while its data output is enabled.
// - Channel A clock owns its pin while its clock output is enabled.
// - Channel A receive pin stays a port; software sets it as input.
// - Channel B receive pin stays a port; software sets it as input.
// - Channel B clock owns its pin while its clock output is enabled.
// - Channel B transmit data owns its pin while its data output is enabled.
// - Sync serial data output owns its pin while enabled.
// - Sync serial clock owns its pin while its clock output is enabled.
// - Sync serial data input pin stays a port; software sets it as input.
// - Four port pins feed interrupt channels four to seven, port kept usable.
// - Converter trigger taken from a port pin, port kept usable.
// - Each analog pin is port or analog input per its enable bit.
// - Reload timer event input taken from a port pin, port kept usable.
// - Port 3 bits 3 to 7 get programmable pull-up while used as port.
`timescale 1ns/1ps
module ppm_pin_mux (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus and peripheral function enables
  input wire logic ext_bus_en_i,
  input wire logic bus_16bit_i,
  input wire logic upper_strobe_en_i,
  input wire logic hold_en_i,
  input wire logic ready_en_i,
  input wire logic clk_out_en_i,
  input wire logic serial_a_tx_en_i,
  input wire logic serial_a_clk_en_i,
  input wire logic serial_b_tx_en_i,
  input wire logic serial_b_clk_en_i,
  input wire logic sync_tx_en_i,
  input wire logic sync_clk_en_i,
  input wire logic [ppm_pkg::PPM_AN_W-1:0] analog_en_i,
  // Port data, direction (1 = output) and pull-up registers
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_data_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_dir_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_pullup_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port4_data_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port4_dir_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port5_data_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port5_dir_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port6_data_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port6_dir_i,
  // Peripheral outputs
  input wire logic upper_byte_write_strobe_i,
  input wire logic hold_ack_out_i,
  input wire logic bus_clock_i,
  input wire logic serial_a_tx_out_i,
  input wire logic serial_a_clock_i,
  input wire logic serial_b_tx_out_i,
  input wire logic serial_b_clock_i,
  input wire logic ext_sync_serial_tx_out_i,
  input wire logic ext_sync_serial_clock_i,
  // Pin levels
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_pin_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port4_pin_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port5_pin_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port6_pin_i,
  // Pin drive; enable low means driven
  output logic [ppm_pkg::PPM_PORT_W-1:0] port3_pin_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port3_pin_oe_n_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port3_pullup_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port4_pin_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port4_pin_oe_n_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port5_pin_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port5_pin_oe_n_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port6_pin_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port6_pin_oe_n_o,
  // Port read-back
  output logic [ppm_pkg::PPM_PORT_W-1:0] port3_read_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port4_read_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port5_read_o,
  output logic [ppm_pkg::PPM_PORT_W-1:0] port6_read_o,
  // Inputs delivered to peripherals
  output logic hold_request_in_o,
  output logic ready_in_o,
  output logic serial_a_clock_o,
  output logic serial_a_rx_in_o,
  output logic serial_b_clock_o,
  output logic serial_b_rx_in_o,
  output logic ext_sync_serial_clock_o,
  output logic ext_sync_serial_rx_in_o,
  output logic [ppm_pkg::PPM_IRQ_W-1:0] ext_irq_inputs_4_to_7_o,
  output logic converter_trigger_in_o,
  output logic reload_timer_a_event_in_o,
  output logic [ppm_pkg::PPM_AN_W-1:0] analog_inputs_o,
  output logic [ppm_pkg::PPM_AN_W-1:0] analog_select_o
);
  import ppm_pkg::*;

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  logic wrh_own;
  logic hold_own;
  logic rdy_own;
  logic clk_own;
  logic [7:0] p3_own;
  logic [7:0] p3_fval;
  logic [7:0] p3_fin;
  logic [7:0] p4_own;
  logic [7:0] p4_fval;
  logic [7:0] p4_fdrv;
  logic [7:0] p3_out_next;
  logic [7:0] p3_oe_n_next;
  logic [7:0] p4_out_next;
  logic [7:0] p4_oe_n_next;

  // Reset release through two flops
  // Assertion stays asynchronous; release lands cleanly on a clock edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  assign wrh_own = ext_bus_en_i & bus_16bit_i & upper_strobe_en_i;
  assign hold_own = ext_bus_en_i & hold_en_i;
  assign rdy_own = ext_bus_en_i & ready_en_i;
  assign clk_own = ext_bus_en_i & clk_out_en_i;

  // Port 3 ownership; hold request and ready are inputs, so pin undriven when owned
  always_comb begin
    p3_own = 8'h00;
    p3_fval = 8'h00;
    p3_fin = 8'h00;
    p3_own[PPM_P3_WRH] = wrh_own;
    p3_fval[PPM_P3_WRH] = upper_byte_write_strobe_i;
    p3_own[PPM_P3_HOLD_REQ] = hold_own;
    p3_fin[PPM_P3_HOLD_REQ] = hold_own;
    p3_own[PPM_P3_HOLD_ACK] = hold_own;
    p3_fval[PPM_P3_HOLD_ACK] = hold_ack_out_i;
    p3_own[PPM_P3_RDY] = rdy_own;
    p3_fin[PPM_P3_RDY] = rdy_own;
    p3_own[PPM_P3_CLK] = clk_own;
    p3_fval[PPM_P3_CLK] = bus_clock_i;
  end

  // Port 4 ownership; serial clocks are driven only when the clock output is on
  // Bits 2 and 3 are receive pins and are never owned
  always_comb begin
    p4_own = 8'h00;
    p4_fval = 8'h00;
    p4_fdrv = 8'h00;
    p4_own[PPM_P4_SA_TX] = serial_a_tx_en_i;
    p4_fval[PPM_P4_SA_TX] = serial_a_tx_out_i;
    p4_own[PPM_P4_SA_CK] = serial_a_clk_en_i;
    p4_fval[PPM_P4_SA_CK] = serial_a_clock_i;
    p4_own[PPM_P4_SB_CK] = serial_b_clk_en_i;
    p4_fval[PPM_P4_SB_CK] = serial_b_clock_i;
    p4_own[PPM_P4_SB_TX] = serial_b_tx_en_i;
    p4_fval[PPM_P4_SB_TX] = serial_b_tx_out_i;
    p4_own[PPM_P4_ES_TX] = sync_tx_en_i;
    p4_fval[PPM_P4_ES_TX] = ext_sync_serial_tx_out_i;
    p4_own[PPM_P4_ES_CK] = sync_clk_en_i;
    p4_fval[PPM_P4_ES_CK] = ext_sync_serial_clock_i;
    p4_fdrv = p4_own;
  end

  // Owned pins take value and enable from the function, not the port
  always_comb begin
    p3_out_next = (p3_own & p3_fval) | (~p3_own & port3_data_i);
    p3_oe_n_next = (p3_own & p3_fin) | (~p3_own & ~port3_dir_i);
    p3_oe_n_next = p3_oe_n_next & ~(p3_own & ~p3_fin);
    p4_out_next = (p4_own & p4_fval) | (~p4_own & port4_data_i);
    p4_oe_n_next = ~((p4_own & p4_fdrv) | (~p4_own & port4_dir_i));
  end

  // Port 3 pin drive
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port3_pin_o <= PPM_BYTE_RST;
      port3_pin_oe_n_o <= PPM_OE_N_RST;
    end else begin
      port3_pin_o <= p3_out_next;
      port3_pin_oe_n_o <= p3_oe_n_next;
    end
  end

  // Port 4 pin drive
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port4_pin_o <= PPM_BYTE_RST;
      port4_pin_oe_n_o <= PPM_OE_N_RST;
    end else begin
      port4_pin_o <= p4_out_next;
      port4_pin_oe_n_o <= p4_oe_n_next;
    end
  end

  // Port 5 pins are always ports; inputs share them
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port5_pin_o <= PPM_BYTE_RST;
      port5_pin_oe_n_o <= PPM_OE_N_RST;
    end else begin
      port5_pin_o <= port5_data_i;
      port5_pin_oe_n_o <= ~port5_dir_i;
    end
  end

  // Analog-selected pins never driven, so no digital drive fights the converter
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port6_pin_o <= PPM_BYTE_RST;
      port6_pin_oe_n_o <= PPM_OE_N_RST;
    end else begin
      port6_pin_o <= port6_data_i & ~analog_en_i;
      port6_pin_oe_n_o <= ~(port6_dir_i & ~analog_en_i);
    end
  end

  // Pull-up only on port 3 bits 3..7 while they act as port bits
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port3_pullup_o <= PPM_BYTE_RST;
    end else begin
      for (int i = 0; i < PPM_PORT_W; i++) begin
        port3_pullup_o[i] <= (i >= PPM_P3_PU_LO) && port3_pullup_i[i] && !p3_own[i];
      end
    end
  end

  // Port read-back; analog pins read zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port3_read_o <= PPM_BYTE_RST;
      port4_read_o <= PPM_BYTE_RST;
      port5_read_o <= PPM_BYTE_RST;
      port6_read_o <= PPM_BYTE_RST;
    end else begin
      port3_read_o <= port3_pin_i;
      port4_read_o <= port4_pin_i;
      port5_read_o <= port5_pin_i;
      port6_read_o <= port6_pin_i & ~analog_en_i;
    end
  end

  // External bus inputs; idle value when the function is off
  // Ready idles high so a port pin never stalls the bus
  // Hold request idles low so a port pin never asks for hold
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_request_in_o <= 1'b0;
      ready_in_o <= 1'b1;
    end else begin
      hold_request_in_o <= hold_own & port3_pin_i[PPM_P3_HOLD_REQ];
      ready_in_o <= rdy_own ? port3_pin_i[PPM_P3_RDY] : 1'b1;
    end
  end

  // Serial inputs; receive pins always tapped, direction set by software
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_a_clock_o <= 1'b0;
      serial_a_rx_in_o <= 1'b1;
      serial_b_clock_o <= 1'b0;
      serial_b_rx_in_o <= 1'b1;
      ext_sync_serial_clock_o <= 1'b0;
      ext_sync_serial_rx_in_o <= 1'b1;
    end else begin
      serial_a_clock_o <= port4_pin_i[PPM_P4_SA_CK];
      serial_a_rx_in_o <= port4_pin_i[PPM_P4_SA_RX];
      serial_b_clock_o <= port4_pin_i[PPM_P4_SB_CK];
      serial_b_rx_in_o <= port4_pin_i[PPM_P4_SB_RX];
      ext_sync_serial_clock_o <= port4_pin_i[PPM_P4_ES_CK];
      ext_sync_serial_rx_in_o <= port5_pin_i[PPM_P5_ES_RX];
    end
  end

  // Interrupt, trigger and timer taps; port function stays usable
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_inputs_4_to_7_o <= PPM_NIB_RST;
      converter_trigger_in_o <= 1'b0;
      reload_timer_a_event_in_o <= 1'b0;
    end else begin
      ext_irq_inputs_4_to_7_o <= port5_pin_i[PPM_P5_IRQ_LO +: PPM_IRQ_W];
      converter_trigger_in_o <= port5_pin_i[PPM_P5_TRIG];
      reload_timer_a_event_in_o <= port5_pin_i[PPM_P5_TMR];
    end
  end

  // Analog taps and selection
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      analog_inputs_o <= PPM_BYTE_RST;
      analog_select_o <= PPM_BYTE_RST;
    end else begin
      analog_inputs_o <= port6_pin_i & analog_en_i;
      analog_select_o <= analog_en_i;
    end
  end
endmodule : ppm_pin_mux

// >>> core/ppm_pkg.sv
// Constants shared by the port 3 to port 6 pin-function multiplexer.
// Assumes one 200 MHz clock domain; all pin inputs synchronous to it.
package ppm_pkg;
  localparam int PPM_CLK_MHZ = 200;
  localparam int PPM_PORT_W = 8;
  localparam int PPM_IRQ_W = 4;
  localparam int PPM_AN_W = 8;
  // Bit positions on port 3
  localparam int PPM_P3_WRH = 3;
  localparam int PPM_P3_HOLD_REQ = 4;
  localparam int PPM_P3_HOLD_ACK = 5;
  localparam int PPM_P3_RDY = 6;
  localparam int PPM_P3_CLK = 7;
  localparam int PPM_P3_PU_LO = 3;
  // Bit positions on port 4
  localparam int PPM_P4_SA_TX = 0;
  localparam int PPM_P4_SA_CK = 1;
  localparam int PPM_P4_SA_RX = 2;
  localparam int PPM_P4_SB_RX = 3;
  localparam int PPM_P4_SB_CK = 4;
  localparam int PPM_P4_SB_TX = 5;
  localparam int PPM_P4_ES_TX = 6;
  localparam int PPM_P4_ES_CK = 7;
  // Bit positions on port 5
  localparam int PPM_P5_ES_RX = 0;
  localparam int PPM_P5_IRQ_LO = 1;
  localparam int PPM_P5_TRIG = 5;
  localparam int PPM_P5_TMR = 6;
  // Reset values
  localparam logic [7:0] PPM_BYTE_RST = 8'h00;
  localparam logic [7:0] PPM_OE_N_RST = 8'hff;
  localparam logic [3:0] PPM_NIB_RST = 4'h0;
endpackage : ppm_pkg

// >>> tb/ppm_periph_model.sv
// Model of the peripherals and board beyond the multiplexer.
// Assumes enable-low pin drive; undriven pins show a pattern that changes every cycle.
`timescale 1ns/1ps
module ppm_periph_model (
  input wire logic clk_i,
  input wire logic [31:0] pin_o_i,
  input wire logic [31:0] oe_n_i,
  output logic [31:0] pin_i_o,
  output logic [8:0] periph_o
);
  logic [31:0] board_reg = 32'h1234abcd;
  always @(posedge clk_i) begin
    board_reg <= board_reg * 32'h0019660d + 32'h3c6ef35f;
  end
  // Peripheral outputs and clocks change freely
  assign periph_o = board_reg[31:23];
  // Driven pins read their drive, others the board level
  assign pin_i_o = (oe_n_i & board_reg) | (~oe_n_i & pin_o_i);
endmodule : ppm_periph_model

// >>> tb/ppm_pin_mux_bench.sv
// Self-checking bench for the port 3 to 6 pin-function multiplexer.
// Assumes the peripheral model resolves pin levels from the mux drive.
`timescale 1ns/1ps
module ppm_pin_mux_bench;
  import ppm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ext_bus_en_i, bus_16bit_i, upper_strobe_en_i, hold_en_i, ready_en_i, clk_out_en_i, serial_a_tx_en_i;
  logic serial_a_clk_en_i, serial_b_tx_en_i, serial_b_clk_en_i, sync_tx_en_i, sync_clk_en_i, bus_clock_i;
  logic upper_byte_write_strobe_i, hold_ack_out_i, serial_a_tx_out_i, serial_a_clock_i, serial_b_tx_out_i;
  logic serial_b_clock_i, ext_sync_serial_tx_out_i, ext_sync_serial_clock_i, hold_request_in_o, ready_in_o;
  logic [7:0] analog_en_i, port3_data_i, port3_dir_i, port3_pullup_i, port4_data_i, port4_dir_i, port5_data_i;
  logic [7:0] port5_dir_i, port6_data_i, port6_dir_i, port3_pin_i, port4_pin_i, port5_pin_i, port6_pin_i;
  logic [7:0] port3_pin_o, port3_pin_oe_n_o, port3_pullup_o, port4_pin_o, port4_pin_oe_n_o, port5_pin_o;
  logic [7:0] port5_pin_oe_n_o, port6_pin_o, port6_pin_oe_n_o, port3_read_o, port4_read_o, port5_read_o;
  logic [7:0] port6_read_o, analog_inputs_o, analog_select_o;
  logic serial_a_clock_o, serial_a_rx_in_o, serial_b_clock_o, serial_b_rx_in_o, ext_sync_serial_clock_o;
  logic ext_sync_serial_rx_in_o, converter_trigger_in_o, reload_timer_a_event_in_o;
  logic [3:0] ext_irq_inputs_4_to_7_o;
  logic [31:0] lfsr_reg = 32'hafa795ae;
  logic [63:0] exp_a, mask_a, exp_b, mask_b, exp_c;
  int num_errors = 0;
  int comparisons = 0;
  int since = 0;
  ppm_pin_mux i_dut (.*);
  ppm_periph_model i_model (
    .clk_i(clk_i),
    .pin_o_i({port6_pin_o, port5_pin_o, port4_pin_o, port3_pin_o}),
    .oe_n_i({port6_pin_oe_n_o, port5_pin_oe_n_o, port4_pin_oe_n_o, port3_pin_oe_n_o}),
    .pin_i_o({port6_pin_i, port5_pin_i, port4_pin_i, port3_pin_i}),
    .periph_o({upper_byte_write_strobe_i, hold_ack_out_i, bus_clock_i, serial_a_tx_out_i, serial_a_clock_i,
      serial_b_tx_out_i, serial_b_clock_i, ext_sync_serial_tx_out_i, ext_sync_serial_clock_i})
  );
  initial forever #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    for (int k = 0; k < 32; k++) lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg;
  endfunction : rnd
  // Mode 1 all functions on, 2 all off, 0 random
  task automatic drive(input logic [1:0] mode);
    logic [31:0] r0;
    r0 = (mode == 2'h1) ? 32'hffffffff : (mode == 2'h2) ? 32'h0 : rnd();
    {ext_bus_en_i, bus_16bit_i, upper_strobe_en_i, hold_en_i, ready_en_i, clk_out_en_i, serial_a_tx_en_i,
      serial_a_clk_en_i, serial_b_tx_en_i, serial_b_clk_en_i, sync_tx_en_i, sync_clk_en_i, analog_en_i} <= r0[19:0];
    {port3_data_i, port3_dir_i, port3_pullup_i, port4_data_i} <= rnd();
    {port4_dir_i, port5_data_i, port5_dir_i, port6_data_i} <= rnd() | {8'h00, 8'h00, 8'h00, 8'h00};
    port6_dir_i <= (mode == 2'h1) ? 8'hff : 8'(rnd());
  endtask : drive
  function automatic void predict();
    logic [7:0] own3, in3, val3, oe3, own4, val4, oe4, oe6;
    own3 = {ext_bus_en_i && clk_out_en_i, 1'b0, ext_bus_en_i && hold_en_i, 1'b0,
      ext_bus_en_i && bus_16bit_i && upper_strobe_en_i, 3'h0};
    in3 = {1'b0, ext_bus_en_i && ready_en_i, 1'b0, ext_bus_en_i && hold_en_i, 4'h0};
    val3 = (port3_data_i & ~own3) | ({bus_clock_i, 1'b0, hold_ack_out_i, 1'b0, upper_byte_write_strobe_i, 3'h0} & own3);
    oe3 = ~(own3 | (port3_dir_i & ~in3));
    own4 = {sync_clk_en_i, sync_tx_en_i, serial_b_tx_en_i, serial_b_clk_en_i, 2'h0, serial_a_clk_en_i, serial_a_tx_en_i};
    val4 = (port4_data_i & ~own4) | (own4 & {ext_sync_serial_clock_i, ext_sync_serial_tx_out_i, serial_b_tx_out_i,
      serial_b_clock_i, 2'h0, serial_a_clock_i, serial_a_tx_out_i});
    oe4 = ~(own4 | port4_dir_i);
    oe6 = ~(port6_dir_i & ~analog_en_i);
    exp_a = {24'h0, val4, oe4, val3, oe3, port3_pullup_i & 8'hf8 & ~own3 & ~in3};
    mask_a = {24'h0, ~oe4, 8'hff, ~oe3, 16'hffff};
    exp_b = {port6_data_i, oe6, port5_data_i, ~port5_dir_i, port6_pin_i & ~analog_en_i, port5_pin_i, port4_pin_i,
      port3_pin_i};
    mask_b = {~oe6, 8'hff, port5_dir_i, 40'hffffffffff};
    exp_c = {34'h0, (ext_bus_en_i && hold_en_i) ? port3_pin_i[4] : 1'b0, (ext_bus_en_i && ready_en_i) ? port3_pin_i[6] :
      1'b1, port4_pin_i[1], port4_pin_i[2], port4_pin_i[4], port4_pin_i[3], port4_pin_i[7], port5_pin_i[6:0],
      port6_pin_i & analog_en_i, analog_en_i};
  endfunction : predict
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input logic [63:0] mask);
    comparisons++;
    if ((got & mask) !== (exp & mask)) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got & mask, exp & mask);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    drive(2'h2);
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 1200; i++) begin
      @(posedge clk_i);
      since = rst_n_i ? since + 1 : 0;
      predict();
      drive(i < 20 ? 2'h1 : i < 40 ? 2'h2 : 2'h0);
      if (i == 600 || i == 603) rst_n_i <= (i == 603);
      @(negedge clk_i);
      if (!rst_n_i) chk({port3_pin_oe_n_o, port4_pin_oe_n_o}, {PPM_OE_N_RST, PPM_OE_N_RST}, 64'hffff);
      if (since >= 3 && rst_n_i) begin
        chk({port4_pin_o, port4_pin_oe_n_o, port3_pin_o, port3_pin_oe_n_o, port3_pullup_o}, exp_a, mask_a);
        chk({port6_pin_o, port6_pin_oe_n_o, port5_pin_o, port5_pin_oe_n_o, port6_read_o, port5_read_o, port4_read_o,
          port3_read_o}, exp_b, mask_b);
        chk({34'h0, hold_request_in_o, ready_in_o, serial_a_clock_o, serial_a_rx_in_o, serial_b_clock_o, serial_b_rx_in_o,
          ext_sync_serial_clock_o, reload_timer_a_event_in_o, converter_trigger_in_o, ext_irq_inputs_4_to_7_o,
          ext_sync_serial_rx_in_o, analog_inputs_o, analog_select_o}, exp_c, 64'hffffffffffffffff);
      end
    end
    results();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    results();
  end
endmodule : ppm_pin_mux_bench

// >>> tb/ppm_pin_mux_chk.sv
// Checker for the pin-function multiplexer, bound to its top module.
// Assumes outputs follow the inputs of the previous edge from the fourth edge after reset release.
`timescale 1ns/1ps
module ppm_pin_mux_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_bus_en_i,
  input wire logic bus_16bit_i,
  input wire logic upper_strobe_en_i,
  input wire logic hold_en_i,
  input wire logic ready_en_i,
  input wire logic clk_out_en_i,
  input wire logic serial_a_tx_en_i,
  input wire logic serial_a_tx_out_i,
  input wire logic upper_byte_write_strobe_i,
  input wire logic hold_ack_out_i,
  input wire logic bus_clock_i,
  input wire logic hold_request_in_o,
  input wire logic ready_in_o,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_pin_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_pullup_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port4_data_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port6_pin_i,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_pin_o,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_pin_oe_n_o,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port3_pullup_o,
  input wire logic [ppm_pkg::PPM_PORT_W-1:0] port4_pin_o,
  input wire logic [ppm_pkg::PPM_AN_W-1:0] analog_en_i,
  input wire logic [ppm_pkg::PPM_AN_W-1:0] analog_inputs_o
);
  import ppm_pkg::*;
  logic [2:0] up_reg;
  // Edges since release, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_reg <= 3'h0;
    else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || up_reg != 3'h4);
  property p_strobe;
    $past(ext_bus_en_i && bus_16bit_i && upper_strobe_en_i) |->
      !port3_pin_oe_n_o[3] && port3_pin_o[3] == $past(upper_byte_write_strobe_i);
  endproperty
  a_strobe: assert property (p_strobe) else $error("upper strobe pin wrong");
  property p_hold_req;
    hold_request_in_o == ($past(ext_bus_en_i && hold_en_i) ? $past(port3_pin_i[4]) : 1'b0);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("hold request wrong");
  property p_hold_ack;
    $past(ext_bus_en_i && hold_en_i) |-> !port3_pin_oe_n_o[5] && port3_pin_o[5] == $past(hold_ack_out_i);
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("hold ack pin wrong");
  property p_ready;
    ready_in_o == ($past(ext_bus_en_i && ready_en_i) ? $past(port3_pin_i[6]) : 1'b1);
  endproperty
  a_ready: assert property (p_ready) else $error("ready input wrong");
  property p_clk;
    $past(ext_bus_en_i && clk_out_en_i) |-> !port3_pin_oe_n_o[7] && port3_pin_o[7] == $past(bus_clock_i);
  endproperty
  a_clk: assert property (p_clk) else $error("clock pin wrong");
  property p_tx_a;
    port4_pin_o[0] == $past(serial_a_tx_en_i ? serial_a_tx_out_i : port4_data_i[0]);
  endproperty
  a_tx_a: assert property (p_tx_a) else $error("channel a tx pin wrong");
  property p_pullup;
    port3_pullup_o[2:0] == 3'h0 &&
      port3_pullup_o[3] == $past(port3_pullup_i[3] && !(ext_bus_en_i && bus_16bit_i && upper_strobe_en_i));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");
  property p_analog;
    analog_inputs_o == $past(port6_pin_i & analog_en_i);
  endproperty
  a_analog: assert property (p_analog) else $error("analog input wrong");
  c_strobe: cover property ($past(ext_bus_en_i && bus_16bit_i && upper_strobe_en_i) && port3_pin_o[3]);
  c_hold: cover property ($past(ext_bus_en_i && hold_en_i) && hold_request_in_o);
  c_analog: cover property (analog_inputs_o != 8'h00);
endmodule : ppm_pin_mux_chk
bind ppm_pin_mux ppm_pin_mux_chk i_chk (.*);
